// File: pkg/scfg_consts.svh
// Constants for the serial configuration port with pin gating
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH
`define SCFG_ADDR_W 7
`define SCFG_DATA_W 16
`define SCFG_GATE_N 11
`define SCFG_OFS_ENABLES 7'h01
`define SCFG_OFS_MASK 7'h10
`define SCFG_OFS_BALUN 7'h30
`define SCFG_RST_ENABLES 16'h0000
`define SCFG_RST_MASK 16'h0000
`define SCFG_RST_BALUN 16'h0000
`define SCFG_BALUN_INPUT_CAP_CODE_LSB 0
`define SCFG_BALUN_OUTPUT_CAP_CODE_LSB 4
`define SCFG_BAL_CODE_W 4
`define SCFG_RW_READ 1'b1
`endif

// File: pkg/scfg_pkg.sv
// Types shared by the serial configuration port
package scfg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_WDATA = 4'h4,
    ST_RDATA = 4'h8
  } frame_state_t;
endpackage : scfg_pkg

// File: logic/pin_sync.sv
// Two-stage synchroniser bank for asynchronous pin inputs
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [WIDTH-1:0] i_async, // Raw pins
  output logic [WIDTH-1:0] o_sync // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // First stage feeds only the second
  always_comb
  begin
    meta_next = i_ce ? i_async : meta_reg;
    sync_next = i_ce ? meta_reg : sync_reg;
  end

  // Register both stages
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      // Reset to each pin's idle level so no false edge follows reset
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule : pin_sync

// File: logic/serial_config_port.sv
// Serial configuration port with fast enable pin gating
`include "scfg_consts.svh"
module serial_config_port #(
  parameter int ADDR_W = `SCFG_ADDR_W,
  parameter int DATA_W = `SCFG_DATA_W,
  parameter int GATE_N = `SCFG_GATE_N
) (
  input wire logic i_clk_sys, // System clock, 25 MHz
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes state when low
  input wire logic i_sclk, // Serial clock from host
  input wire logic i_cs_n, // Chip select, active low
  input wire logic i_sdio, // Serial data in from host
  output logic o_sdio, // Serial data out to host
  output logic o_sdio_oe, // High while the port drives data
  input wire logic i_fast_enable_pin, // Fast enable pin
  output logic [GATE_N-1:0] o_block_en, // Gated block enables
  output logic [`SCFG_BAL_CODE_W-1:0] o_balun_input_cap_code, // Balun input cap
  output logic [`SCFG_BAL_CODE_W-1:0] o_balun_output_cap_code // Balun output cap
);
  localparam int CNT_W = 5;

  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdio_s;
  logic fast_s;
  logic fast_meta_reg;
  logic fast_reg;
  logic sclk_d_reg;
  logic cs_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  scfg_pkg::frame_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] shift_reg, shift_next;
  logic [DATA_W-1:0] enables_reg, enables_next;
  logic [DATA_W-1:0] mask_reg, mask_next;
  logic [DATA_W-1:0] balun_reg, balun_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic [GATE_N-1:0] blk_reg, blk_next;

  // Register readback by address; unmapped reads return zero
  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] b);
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      `SCFG_OFS_ENABLES: r = e;
      `SCFG_OFS_MASK: r = m;
      `SCFG_OFS_BALUN: r = b;
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  // Serial pins cross into the system clock; select resets to its idle high
  pin_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_async({i_sclk, i_cs_n, i_sdio}),
    .o_sync(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdio_s = pins_s[0];
  assign fast_s = fast_reg;

  // Edge detection on synchronised levels only
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_reg;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_reg;
  assign cs_rise = cs_n_s && !cs_d_reg;

  // Frame engine: address, direction, then data
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    shift_next = shift_reg;
    enables_next = enables_reg;
    mask_next = mask_reg;
    balun_next = balun_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    if (cs_n_s)
    begin
      state_next = scfg_pkg::ST_IDLE;
      cnt_next = '0;
      oe_next = 1'b0;
      // Commit whatever was latched; partial writes land right-aligned
      if (cs_rise && state_reg == scfg_pkg::ST_WDATA && cnt_reg != '0)
      begin
        case (addr_reg)
          `SCFG_OFS_ENABLES: enables_next = shift_reg;
          `SCFG_OFS_MASK: mask_next = shift_reg;
          `SCFG_OFS_BALUN: balun_next = shift_reg;
          default: ;
        endcase
      end
    end
    else
    begin
      case (state_reg)
        scfg_pkg::ST_IDLE:
        begin
          state_next = scfg_pkg::ST_ADDR;
          cnt_next = '0;
          shift_next = '0;
        end
        scfg_pkg::ST_ADDR:
        begin
          if (sclk_rise)
          begin
            if (cnt_reg < CNT_W'(ADDR_W))
            begin
              addr_next = {addr_reg[ADDR_W-2:0], sdio_s};
              cnt_next = cnt_reg + 1'b1;
            end
            else if (sdio_s == `SCFG_RW_READ)
            begin
              state_next = scfg_pkg::ST_RDATA;
              cnt_next = '0;
              shift_next = read_mux(addr_reg, enables_reg, mask_reg, balun_reg);
            end
            else
            begin
              state_next = scfg_pkg::ST_WDATA;
              cnt_next = '0;
              shift_next = '0;
            end
          end
        end
        scfg_pkg::ST_WDATA:
        begin
          if (sclk_rise)
          begin
            // Excess bits push the oldest out, keeping the last sixteen
            shift_next = {shift_reg[DATA_W-2:0], sdio_s};
            if (cnt_reg != '1)
              cnt_next = cnt_reg + 1'b1;
          end
        end
        scfg_pkg::ST_RDATA:
        begin
          // Present next bit after each falling edge, MSB first
          if (sclk_fall)
          begin
            oe_next = 1'b1;
            sdo_next = shift_reg[DATA_W-1];
            shift_next = {shift_reg[DATA_W-2:0], 1'b0};
          end
        end
        default:
        begin
          state_next = scfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pin gating is computed from the synced pin and registered into blk_reg
  always_comb
  begin
    for (int i = 0; i < GATE_N; i++)
      blk_next[i] = enables_reg[i] && (!mask_reg[i] || fast_s);
  end

  // State registers
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= scfg_pkg::ST_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      shift_reg <= '0;
      enables_reg <= `SCFG_RST_ENABLES;
      mask_reg <= `SCFG_RST_MASK;
      balun_reg <= `SCFG_RST_BALUN;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      blk_reg <= '0;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      fast_meta_reg <= 1'b0;
      fast_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      shift_reg <= shift_next;
      enables_reg <= enables_next;
      mask_reg <= mask_next;
      balun_reg <= balun_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      blk_reg <= blk_next;
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
      fast_meta_reg <= i_fast_enable_pin;
      fast_reg <= fast_meta_reg;
    end
  end

  assign o_sdio = sdo_reg;
  assign o_sdio_oe = oe_reg;
  assign o_block_en = blk_reg;
  assign o_balun_input_cap_code = balun_reg[`SCFG_BALUN_INPUT_CAP_CODE_LSB +: `SCFG_BAL_CODE_W];
  assign o_balun_output_cap_code = balun_reg[`SCFG_BALUN_OUTPUT_CAP_CODE_LSB +: `SCFG_BAL_CODE_W];

  // Gated enable 0 follows the synced pin one cycle later when its enable and mask are set
  property p_gate_follow;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && enables_reg[0] && mask_reg[0] && $stable(enables_reg[0]) && $stable(mask_reg[0])
      |=> (blk_reg[0] == $past(fast_s));
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("gated enable not following pin");

  property p_en_off;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && !enables_reg[3] |=> !blk_reg[3];
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled block came on");

  property p_mask_off;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && enables_reg[GATE_N-1] && !mask_reg[GATE_N-1] |=> blk_reg[GATE_N-1];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("unmasked block not enabled");

  property p_idle_quiet;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      cs_n_s && i_ce |=> (!oe_reg && state_reg == scfg_pkg::ST_IDLE);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("port active while deselected");

  property p_wr_commit;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && cs_rise && state_reg == scfg_pkg::ST_WDATA && cnt_reg != '0
      && addr_reg == `SCFG_OFS_BALUN |=> balun_reg == $past(shift_reg);
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write not committed");

  property p_rd_msb;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && state_reg == scfg_pkg::ST_RDATA && sclk_fall && !cs_n_s
      |=> o_sdio == $past(shift_reg[DATA_W-1]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("read bit mismatch");

  property p_wr_shift;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && state_reg == scfg_pkg::ST_WDATA && sclk_rise && !cs_n_s
      |=> shift_reg == {$past(shift_reg[DATA_W-2:0]), $past(sdio_s)};
  endproperty
  a_wr_shift: assert property (p_wr_shift) else $error("write shift wrong");

  property p_addr_len;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      state_reg == scfg_pkg::ST_ADDR |-> cnt_reg <= CNT_W'(ADDR_W);
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address field too long");

  property p_bal_split;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_balun_output_cap_code == balun_reg[7:4] && o_balun_input_cap_code == balun_reg[3:0];
  endproperty
  a_bal_split: assert property (p_bal_split) else $error("balun field misplaced");
endmodule : serial_config_port

// File: dv/host_model.sv
// Host controller model for the three-wire configuration port
module host_model (
  input wire logic i_clk_sys, // Pacing clock
  input wire logic i_sdio, // Resolved data wire
  output logic o_sclk, // Serial clock, idles low
  output logic o_cs_n, // Select, active low
  output logic o_sdio // Host drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdio = 1'b0;
  end
  // Four clocks a half bit gives a 320 ns serial clock
  task automatic half();
    repeat (4) @(posedge i_clk_sys);
  endtask : half
  // Frame: address, read flag, then n data bits; keeps first 16 read bits
  task automatic frame(input logic [6:0] addr, input logic rw, input logic [31:0] data,
    input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    half();
    for (int i = 0; i < n + 8; i++)
    begin
      o_sclk <= 1'b0;
      if (i < 7)
        o_sdio <= addr[6 - i];
      else if (i == 7)
        o_sdio <= rw;
      else if (rw)
        o_sdio <= ~o_sdio; // Released: toggles so a stale level never passes
      else
        o_sdio <= data[n + 7 - i];
      half();
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      // Bits past the sixteenth are not relied on
      if (rw && i >= 8 && i < 24)
        rd = {rd[14:0], i_sdio};
      repeat (2) @(posedge i_clk_sys);
    end
    o_sclk <= 1'b0;
    half();
    o_cs_n <= 1'b1;
    o_sdio <= ~o_sdio;
    repeat (8) @(posedge i_clk_sys);
  endtask : frame
  // Clock and data wiggle with select high
  task automatic noise();
    for (int i = 0; i < 24; i++)
    begin
      o_sclk <= ~o_sclk;
      o_sdio <= ~o_sdio;
      half();
    end
  endtask : noise
endmodule : host_model

// File: dv/tb_top.sv
// Self-checking bench for the serial configuration port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic fast_pin = 1'b0;
  logic sclk, cs_n, host_sdio, dev_sdio, dev_oe, sdio_wire;
  logic [10:0] block_en;
  logic [3:0] cin, cout;
  int failures = 0;
  int check_count = 0;
  // Device wins the shared wire while it drives
  assign sdio_wire = dev_oe ? dev_sdio : host_sdio;
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  serial_config_port uut (
    .i_clk_sys(clk_sys),
    .i_nrst(nrst),
    .i_ce(1'b1),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_sdio(sdio_wire),
    .o_sdio(dev_sdio),
    .o_sdio_oe(dev_oe),
    .i_fast_enable_pin(fast_pin),
    .o_block_en(block_en),
    .o_balun_input_cap_code(cin),
    .o_balun_output_cap_code(cout)
  );
  host_model u_host (
    .i_clk_sys(clk_sys),
    .i_sdio(sdio_wire),
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_sdio(host_sdio)
  );
  task automatic report_and_stop();
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Bounded wait for the outputs to settle, then compare all three
  task automatic expect_out(input logic [15:0] en, input logic [15:0] mask,
    input logic [15:0] bal);
    logic [10:0] gate;
    gate = en[10:0] & (~mask[10:0] | {11{fast_pin}});
    for (int i = 0; i < 16 && !(block_en === gate && cin === bal[3:0]
      && cout === bal[7:4]); i++)
      @(posedge clk_sys);
    check("block_en", {5'h00, gate}, {5'h00, block_en});
    check("balun_in", {12'h000, bal[3:0]}, {12'h000, cin});
    check("balun_out", {12'h000, bal[7:4]}, {12'h000, cout});
  endtask : expect_out
  task automatic wr(input logic [6:0] addr, input logic [31:0] data, input int n);
    logic [15:0] ignored;
    u_host.frame(addr, 1'b0, data, n, ignored);
  endtask : wr
  task automatic rd_check(input string name, input logic [6:0] addr,
    input logic [15:0] exp, input int n);
    logic [15:0] got;
    u_host.frame(addr, 1'b1, 32'h00000000, n, got);
    check(name, exp, got);
    check("oe_idle", 16'h0000, {15'h0000, dev_oe});
  endtask : rd_check
  // Pin changes land one edge before the expectation is formed
  task automatic set_pin(input logic v);
    fast_pin <= v;
    @(posedge clk_sys);
  endtask : set_pin
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expect_out(16'h0000, 16'h0000, 16'h0000);
    rd_check("rd_enables", 7'h01, 16'h0000, 16);
    rd_check("rd_mask", 7'h10, 16'h0000, 16);
    rd_check("rd_balun", 7'h30, 16'h0000, 16);
    wr(7'h01, 32'h00000F0F, 16);
    expect_out(16'h0F0F, 16'h0000, 16'h0000);
    wr(7'h10, 32'h00000555, 16);
    expect_out(16'h0F0F, 16'h0555, 16'h0000);
    set_pin(1'b1);
    expect_out(16'h0F0F, 16'h0555, 16'h0000);
    set_pin(1'b0);
    expect_out(16'h0F0F, 16'h0555, 16'h0000);
    rd_check("rd_enables", 7'h01, 16'h0F0F, 18);
    wr(7'h30, 32'h000000F3, 16);
    expect_out(16'h0F0F, 16'h0555, 16'h00F3);
    wr(7'h30, 32'h000000A5, 8);
    expect_out(16'h0F0F, 16'h0555, 16'h00A5);
    wr(7'h30, 32'h00000000, 0);
    expect_out(16'h0F0F, 16'h0555, 16'h00A5);
    rd_check("rd_balun", 7'h30, 16'h00A5, 16);
    wr(7'h30, 32'h000ABCDE, 20);
    expect_out(16'h0F0F, 16'h0555, 16'hBCDE);
    u_host.noise();
    expect_out(16'h0F0F, 16'h0555, 16'hBCDE);
    wr(7'h7F, 32'h0000FFFF, 16);
    rd_check("rd_unmapped", 7'h7F, 16'h0000, 16);
    rd_check("rd_mask", 7'h10, 16'h0555, 16);
    expect_out(16'h0F0F, 16'h0555, 16'hBCDE);
    // Low band setting: input code fifteen, output code three
    wr(7'h30, 32'h0000003F, 16);
    expect_out(16'h0F0F, 16'h0555, 16'h003F);
    // Second reset in mid-run clears the enables, mask and balun registers
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expect_out(16'h0000, 16'h0000, 16'h0000);
    rd_check("rd_balun_rst", 7'h30, 16'h0000, 16);
    rd_check("rd_enables_rst", 7'h01, 16'h0000, 16);
    report_and_stop();
  end
endmodule : tb_top
